// [cdg_defs.vh]
`ifndef CDG_DEFS_VH
`define CDG_DEFS_VH
// Overview of operation
// - ratio field bits 14..12 set core clock; code 000 runs it at x1.
// - ratio field bits 11..9 set bus clock; code 001 gives half rate.
// - ratio field bits 8..6 set peripheral clock; code 001 gives half rate.
// - ratio field bits 5..3 set secondary timer clock; code 000 runs x1.
// - ratio field bits 2..0 set primary timer clock; code 001 gives half rate.
// - stop control a bit 7 set stops the RAM clock, clear runs it.
// - stop control a bit 6 set stops the ROM clock, clear runs it.
// - stop control a bit 4 set stops the transfer controller clock.
// - stop control a bit 3 set stops the DMA controller clock.
// - stop control b bit 7 set stops the secondary multifunction timer clock.
// - stop control b bit 6 set stops the primary multifunction timer clock.
// - stop control b bit 5 set stops the compare-match timer clock.
// - stop control b bit 2 set stops converter unit two clock.
// - stop control b bit 1 set stops converter unit one clock.
// - stop control b bit 0 set stops converter unit zero clock.

// register byte addresses (word aligned)
`define CDG_ADDR_RATIO 4'h0
`define CDG_ADDR_STOPA 4'h4
`define CDG_ADDR_STOPB 4'h8
`define CDG_ADDR_STAT 4'hc
// reset values
`define CDG_RATIO_RST 16'h0241
`define CDG_STOPA_RST 8'h28
`define CDG_STOPB_RST 8'hfe
`define CDG_RATIO_MASK 16'h7fff
`define CDG_STOPA_MASK 8'hd8
`define CDG_STOPB_MASK 8'he7
`define CDG_STOPA_RSVD 8'h20
`define CDG_STOPB_RSVD 8'h18
// ratio field low bit positions
`define CDG_POS_CORE 12
`define CDG_POS_BUS 9
`define CDG_POS_PER 6
`define CDG_POS_STMR 3
`define CDG_POS_PTMR 0
// ratio codes
`define CDG_CODE_X1 3'h0
`define CDG_CODE_X2 3'h1
`define CDG_CODE_X4 3'h2
`define CDG_CODE_X8 3'h3
// stop bit positions
`define CDG_BIT_RAM 7
`define CDG_BIT_ROM 6
`define CDG_BIT_XFER 4
`define CDG_BIT_DMA 3
`define CDG_BIT_STMR 7
`define CDG_BIT_PTMR 6
`define CDG_BIT_CMT 5
`define CDG_BIT_CNV2 2
`define CDG_BIT_CNV1 1
`define CDG_BIT_CNV0 0
`define CDG_NUM_DIV 5
`define CDG_NUM_GATE 10
`define CDG_PHASE_W 3
`endif

// [cdg_ratio_div.v]
`include "cdg_defs.vh"
// one enable pulse per divided period; code selects 1,2,4 or 8
module cdg_ratio_div
(
    input wire clk_i,
    input wire rst_i,
    input wire [2:0] ratio_i,
    output reg en_o
);
    reg [`CDG_PHASE_W-1:0] phase;
    reg [`CDG_PHASE_W-1:0] last;

    // --------------------------------
    // terminal count per ratio code
    // --------------------------------
    always @*
    begin
        case (ratio_i)
            `CDG_CODE_X1: last = 3'h0;
            `CDG_CODE_X2: last = 3'h1;
            `CDG_CODE_X4: last = 3'h3;
            `CDG_CODE_X8: last = 3'h7;
            default: last = 3'h0;
        endcase
    end

    // counter restarts at terminal, so a ratio change lands within one period
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            phase <= 3'h0;
            en_o <= 1'b0;
        end
        else if (phase >= last)
        begin
            phase <= 3'h0;
            en_o <= 1'b1;
        end
        else
        begin
            phase <= phase + 3'h1;
            en_o <= 1'b0;
        end
    end
endmodule

// [cdg_gate_cell.v]
`include "cdg_defs.vh"
// enable-form gate: stop is taken at a clock edge, so every pulse stays whole
module cdg_gate_cell
(
    input wire clk_i,
    input wire rst_i,
    input wire en_i,
    input wire stop_i,
    output reg gated_o,
    output reg running_o
);
    // --------------------------------
    // follow the stop bit every cycle
    // --------------------------------
    // waiting for a low source enable would freeze gates on x1 sources for good;
    // a registered one-cycle enable cannot be truncated, so no wait is needed
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            running_o <= 1'b0;
            gated_o <= 1'b0;
        end
        else
        begin
            running_o <= ~stop_i;
            gated_o <= en_i & running_o;
        end
    end
endmodule

// [cdg_clock_ctrl.v]
`include "cdg_defs.vh"
// clock ratio and module stop control with classic wishbone slave
module cdg_clock_ctrl
(
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [3:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    output reg core_clk_en_o,
    output reg bus_clk_en_o,
    output reg peripheral_clk_en_o,
    output reg secondary_timer_clock_en_o,
    output reg primary_timer_clock_en_o,
    output reg ram_clk_en_o,
    output reg rom_clk_en_o,
    output reg data_transfer_controller_clk_en_o,
    output reg dma_controller_clk_en_o,
    output reg secondary_multifunction_timer_clk_en_o,
    output reg primary_multifunction_timer_clk_en_o,
    output reg compare_match_timer_clk_en_o,
    output reg converter2_clk_en_o,
    output reg converter1_clk_en_o,
    output reg converter0_clk_en_o
);
    reg [15:0] clock_ratio_control;
    reg [7:0] module_stop_control_a;
    reg [7:0] module_stop_control_b;
    wire [`CDG_NUM_DIV-1:0] div_en;
    wire [`CDG_NUM_GATE-1:0] gate_src;
    wire [`CDG_NUM_GATE-1:0] gate_stop;
    wire [`CDG_NUM_GATE-1:0] gate_out;
    wire [`CDG_NUM_GATE-1:0] gate_run;
    wire [14:0] ratio_bus;
    wire bus_req;
    wire bus_wr;
    wire [31:0] next_dat;

    // --------------------------------
    // field extraction
    // --------------------------------
    function [2:0] ratio_field;
        input [15:0] reg_value;
        input integer pos;
        begin
            ratio_field = reg_value[pos +: 3];
        end
    endfunction

    // byte lane merge; only lanes 0 and 1 hold bits
    function [15:0] lane_merge;
        input [15:0] old_value;
        input [15:0] new_value;
        input [1:0] sel;
        begin
            lane_merge = old_value;
            if (sel[0])
            begin
                lane_merge[7:0] = new_value[7:0];
            end
            if (sel[1])
            begin
                lane_merge[15:8] = new_value[15:8];
            end
        end
    endfunction

    // --------------------------------
    // wishbone slave: one wait cycle, ack then drop
    // --------------------------------
    assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    // master samples ack at this edge, so the write lands here and nowhere else
    assign bus_wr = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i;

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
        end
        else
        begin
            wb_ack_o <= bus_req;
        end
    end

    // writes take effect at the acking edge of the request
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            clock_ratio_control <= `CDG_RATIO_RST;
            module_stop_control_a <= `CDG_STOPA_RST;
            module_stop_control_b <= `CDG_STOPB_RST;
        end
        else if (bus_wr)
        begin
            case (wb_adr_i)
                `CDG_ADDR_RATIO:
                begin
                    clock_ratio_control <= lane_merge(clock_ratio_control, wb_dat_i[15:0],
                        wb_sel_i[1:0]) & `CDG_RATIO_MASK;
                end
                `CDG_ADDR_STOPA:
                begin
                    if (wb_sel_i[0])
                    begin
                        module_stop_control_a <= (wb_dat_i[7:0] & `CDG_STOPA_MASK)
                            | `CDG_STOPA_RSVD;
                    end
                end
                `CDG_ADDR_STOPB:
                begin
                    if (wb_sel_i[0])
                    begin
                        module_stop_control_b <= (wb_dat_i[7:0] & `CDG_STOPB_MASK)
                            | `CDG_STOPB_RSVD;
                    end
                end
                default:
                begin
                    clock_ratio_control <= clock_ratio_control;
                end
            endcase
        end
    end

    // --------------------------------
    // read mux; status word shows live gate states
    // --------------------------------
    assign next_dat = (wb_adr_i == `CDG_ADDR_RATIO) ? {16'h0000, clock_ratio_control} :
                      (wb_adr_i == `CDG_ADDR_STOPA) ? {24'h000000, module_stop_control_a} :
                      (wb_adr_i == `CDG_ADDR_STOPB) ? {24'h000000, module_stop_control_b} :
                      (wb_adr_i == `CDG_ADDR_STAT) ? {22'h0, gate_run} :
                      32'h00000000;

    // unmapped addresses ack with zero data
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_dat_o <= 32'h00000000;
        end
        else if (bus_req && !wb_we_i)
        begin
            wb_dat_o <= next_dat;
        end
    end

    // --------------------------------
    // dividers: core, bus, peripheral, secondary timer, primary timer
    // --------------------------------
    assign ratio_bus = {
        ratio_field(clock_ratio_control, `CDG_POS_CORE),
        ratio_field(clock_ratio_control, `CDG_POS_BUS),
        ratio_field(clock_ratio_control, `CDG_POS_PER),
        ratio_field(clock_ratio_control, `CDG_POS_STMR),
        ratio_field(clock_ratio_control, `CDG_POS_PTMR)
    };

    genvar gi;
    generate
        for (gi = 0; gi < `CDG_NUM_DIV; gi = gi + 1)
        begin : g_div
            cdg_ratio_div u_div
            (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .ratio_i(ratio_bus[gi*3 +: 3]),
                .en_o(div_en[gi])
            );
        end
    endgenerate

    // div_en index: 4 core, 3 bus, 2 peripheral, 1 secondary timer, 0 primary timer
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            core_clk_en_o <= 1'b0;
            bus_clk_en_o <= 1'b0;
            peripheral_clk_en_o <= 1'b0;
            secondary_timer_clock_en_o <= 1'b0;
            primary_timer_clock_en_o <= 1'b0;
        end
        else
        begin
            core_clk_en_o <= div_en[4];
            bus_clk_en_o <= div_en[3];
            peripheral_clk_en_o <= div_en[2];
            secondary_timer_clock_en_o <= div_en[1];
            primary_timer_clock_en_o <= div_en[0];
        end
    end

    // --------------------------------
    // module gates: memories on core, engines on bus, units on their clocks
    // --------------------------------
    assign gate_src = {div_en[4], div_en[4], div_en[3], div_en[3], div_en[1],
                       div_en[0], div_en[2], div_en[2], div_en[2], div_en[2]};
    assign gate_stop = {
        module_stop_control_a[`CDG_BIT_RAM],
        module_stop_control_a[`CDG_BIT_ROM],
        module_stop_control_a[`CDG_BIT_XFER],
        module_stop_control_a[`CDG_BIT_DMA],
        module_stop_control_b[`CDG_BIT_STMR],
        module_stop_control_b[`CDG_BIT_PTMR],
        module_stop_control_b[`CDG_BIT_CMT],
        module_stop_control_b[`CDG_BIT_CNV2],
        module_stop_control_b[`CDG_BIT_CNV1],
        module_stop_control_b[`CDG_BIT_CNV0]
    };

    generate
        for (gi = 0; gi < `CDG_NUM_GATE; gi = gi + 1)
        begin : g_gate
            cdg_gate_cell u_gate
            (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .en_i(gate_src[gi]),
                .stop_i(gate_stop[gi]),
                .gated_o(gate_out[gi]),
                .running_o(gate_run[gi])
            );
        end
    endgenerate

    // gated enables re-registered so every top output is a flop
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ram_clk_en_o <= 1'b0;
            rom_clk_en_o <= 1'b0;
            data_transfer_controller_clk_en_o <= 1'b0;
            dma_controller_clk_en_o <= 1'b0;
            secondary_multifunction_timer_clk_en_o <= 1'b0;
            primary_multifunction_timer_clk_en_o <= 1'b0;
            compare_match_timer_clk_en_o <= 1'b0;
            converter2_clk_en_o <= 1'b0;
            converter1_clk_en_o <= 1'b0;
            converter0_clk_en_o <= 1'b0;
        end
        else
        begin
            ram_clk_en_o <= gate_out[9];
            rom_clk_en_o <= gate_out[8];
            data_transfer_controller_clk_en_o <= gate_out[7];
            dma_controller_clk_en_o <= gate_out[6];
            secondary_multifunction_timer_clk_en_o <= gate_out[5];
            primary_multifunction_timer_clk_en_o <= gate_out[4];
            compare_match_timer_clk_en_o <= gate_out[3];
            converter2_clk_en_o <= gate_out[2];
            converter1_clk_en_o <= gate_out[1];
            converter0_clk_en_o <= gate_out[0];
        end
    end
endmodule

// [cdg_clock_ctrl_assertions.sv]
module cdg_clock_ctrl_chk
(
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [3:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire wb_ack_o,
    input wire core_clk_en_o,
    input wire bus_clk_en_o,
    input wire peripheral_clk_en_o,
    input wire secondary_timer_clock_en_o,
    input wire primary_timer_clock_en_o,
    input wire ram_clk_en_o,
    input wire rom_clk_en_o,
    input wire data_transfer_controller_clk_en_o,
    input wire dma_controller_clk_en_o,
    input wire secondary_multifunction_timer_clk_en_o,
    input wire primary_multifunction_timer_clk_en_o,
    input wire compare_match_timer_clk_en_o,
    input wire converter2_clk_en_o,
    input wire converter1_clk_en_o,
    input wire converter0_clk_en_o
);
timeunit 1ns;
timeprecision 1ps;
reg [15:0] sh;
reg [7:0] sa;
reg [7:0] sb;
reg [3:0] q;
// ----------------------------------------
// ratio shadow and settle counter
// ----------------------------------------
// dividers take up to one period to follow a write, so checks wait until q saturates
always @(posedge clk_i)
begin
    if (rst_i)
    begin
        sh <= 16'h0241;
        sa <= 8'h28;
        sb <= 8'hfe;
        q <= 4'h0;
    end
    else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o)
    begin
        if (wb_adr_i == 4'h0 && wb_sel_i[0])
            sh[7:0] <= wb_dat_i[7:0];
        if (wb_adr_i == 4'h0 && wb_sel_i[1])
            sh[15:8] <= wb_dat_i[15:8];
        if (wb_adr_i == 4'h4 && wb_sel_i[0])
            sa <= wb_dat_i[7:0];
        if (wb_adr_i == 4'h8 && wb_sel_i[0])
            sb <= wb_dat_i[7:0];
        q <= 4'h0;
    end
    else if (q != 4'hf)
        q <= q + 4'h1;
end
default clocking @(posedge clk_i); endclocking
default disable iff (rst_i);
AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
AST_CORE_X1: assert property (q == 4'hf && sh[14:12] == 3'h0 |-> core_clk_en_o)
    else $error("core not x1");
AST_BUS_HALF: assert property (q == 4'hf && sh[11:9] == 3'h1 && bus_clk_en_o
    |=> !bus_clk_en_o ##1 bus_clk_en_o) else $error("bus not half");
AST_PER_HALF: assert property (q == 4'hf && sh[8:6] == 3'h1 && peripheral_clk_en_o
    |=> !peripheral_clk_en_o ##1 peripheral_clk_en_o) else $error("per not half");
AST_STMR_X1: assert property (q == 4'hf && sh[5:3] == 3'h0
    |-> secondary_timer_clock_en_o) else $error("stmr not x1");
AST_PTMR_HALF: assert property (q == 4'hf && sh[2:0] == 3'h1 && primary_timer_clock_en_o
    |=> !primary_timer_clock_en_o ##1 primary_timer_clock_en_o) else $error("ptmr");
AST_CORE_GATE: assert property (ram_clk_en_o || rom_clk_en_o
    |-> $past(core_clk_en_o)) else $error("core gate pulse");
AST_BUS_GATE: assert property (data_transfer_controller_clk_en_o
    || dma_controller_clk_en_o |-> $past(bus_clk_en_o)) else $error("bus gate pulse");
AST_TMR_GATE: assert property ((!secondary_multifunction_timer_clk_en_o
    || $past(secondary_timer_clock_en_o)) && (!primary_multifunction_timer_clk_en_o
    || $past(primary_timer_clock_en_o))) else $error("timer gate pulse");
AST_PER_GATE: assert property (compare_match_timer_clk_en_o || converter2_clk_en_o
    || converter1_clk_en_o || converter0_clk_en_o |-> $past(peripheral_clk_en_o))
    else $error("per gate pulse");
// stop bits settle within a few cycles of the write, q covers that
AST_STOP_A: assert property (q == 4'hf
    |-> !(sa[7] && ram_clk_en_o) && !(sa[6] && rom_clk_en_o)
    && !(sa[4] && data_transfer_controller_clk_en_o) && !(sa[3] && dma_controller_clk_en_o))
    else $error("stopped memory or engine clocked");
AST_STOP_B: assert property (q == 4'hf
    |-> !(sb[7] && secondary_multifunction_timer_clk_en_o)
    && !(sb[6] && primary_multifunction_timer_clk_en_o)
    && !(sb[5] && compare_match_timer_clk_en_o)
    && !(sb[2] && converter2_clk_en_o) && !(sb[1] && converter1_clk_en_o)
    && !(sb[0] && converter0_clk_en_o)) else $error("stopped unit clocked");
AST_RAM_RUN: assert property (q == 4'hf && !sa[7] && core_clk_en_o
    |=> ram_clk_en_o) else $error("running ram missed a core pulse");
AST_CNV0_RUN: assert property (q == 4'hf && !sb[0] && peripheral_clk_en_o
    |=> converter0_clk_en_o) else $error("running converter missed a pulse");
endmodule

// [cdg_consumer_model.sv]
module cdg_consumer_model
(
    input wire clk_i,
    input wire rst_i,
    input wire clr_i,
    input wire [9:0] en_i,
    output logic [9:0] seen_o
);
timeunit 1ns;
timeprecision 1ps;
// each consumer only records that an edge reached it; stopped ones must stay 0
always @(posedge clk_i)
begin
    if (rst_i || clr_i)
        seen_o <= 10'h000;
    else
        seen_o <= seen_o | en_i;
end
endmodule

// [tb_clock_divider_module_gating.sv]
module tb_clock_divider_module_gating;
timeunit 1ns;
timeprecision 1ps;
typedef struct {
    logic [15:0] rw;
    logic [7:0] aw;
    logic [7:0] bw;
    logic [15:0] rr;
    logic [7:0] ar;
    logic [7:0] br;
    logic [9:0] sn;
} cdg_row_t;
logic clk_i = 1'b0;
logic rst_i = 1'b1;
logic wb_cyc_i = 1'b0;
logic wb_stb_i = 1'b0;
logic wb_we_i = 1'b0;
logic [3:0] wb_adr_i = 4'h0;
logic [3:0] wb_sel_i = 4'hf;
logic [31:0] wb_dat_i = 32'h0;
logic clr = 1'b0;
logic [31:0] q;
integer fails = 0;
integer n_checks = 0;
integer k;
cdg_row_t rows [4];
wire [31:0] wb_dat_o;
wire wb_ack_o, core_clk_en_o, bus_clk_en_o, peripheral_clk_en_o;
wire secondary_timer_clock_en_o, primary_timer_clock_en_o, ram_clk_en_o, rom_clk_en_o;
wire data_transfer_controller_clk_en_o, dma_controller_clk_en_o;
wire secondary_multifunction_timer_clk_en_o, primary_multifunction_timer_clk_en_o;
wire compare_match_timer_clk_en_o, converter2_clk_en_o, converter1_clk_en_o;
wire converter0_clk_en_o;
wire [9:0] seen;
// 200 MHz system clock
always #2.5 clk_i = ~clk_i;
cdg_clock_ctrl uut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .core_clk_en_o, .bus_clk_en_o, .peripheral_clk_en_o,
    .secondary_timer_clock_en_o, .primary_timer_clock_en_o, .ram_clk_en_o, .rom_clk_en_o,
    .data_transfer_controller_clk_en_o, .dma_controller_clk_en_o,
    .secondary_multifunction_timer_clk_en_o, .primary_multifunction_timer_clk_en_o,
    .compare_match_timer_clk_en_o, .converter2_clk_en_o, .converter1_clk_en_o,
    .converter0_clk_en_o);
cdg_consumer_model peer (.clk_i, .rst_i, .clr_i(clr), .seen_o(seen),
    .en_i({ram_clk_en_o, rom_clk_en_o, data_transfer_controller_clk_en_o,
    dma_controller_clk_en_o, secondary_multifunction_timer_clk_en_o,
    primary_multifunction_timer_clk_en_o, compare_match_timer_clk_en_o,
    converter2_clk_en_o, converter1_clk_en_o, converter0_clk_en_o}));
// ----------------------------------------
// tasks
// ----------------------------------------
task print_verdict;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
        $display("No errors found");
    else
        $display("Errors were found");
    $finish;
endtask
task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
        fails++;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
endtask
// classic cycle: hold everything until ack is sampled, then one idle cycle
task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    integer i;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    for (i = 0; i < 20; i++)
    begin
        @(posedge clk_i);
        if (wb_ack_o === 1'b1)
            break;
    end
    if (i == 20)
    begin
        fails++;
        print_verdict();
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk_i);
endtask
// slowest ratio is /8, so 40 cycles shows every running consumer
task automatic observe(input logic [9:0] exp);
    repeat (16) @(posedge clk_i);
    clr <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
    repeat (40) @(posedge clk_i);
    chk({22'h0, seen}, {22'h0, exp});
endtask
task automatic reset_dut(input integer n);
    rst_i <= 1'b1;
    repeat (n) @(posedge clk_i);
    chk({29'h0, wb_ack_o, core_clk_en_o, ram_clk_en_o}, 32'h0);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, 4'h0, 32'h0);
    chk(q, 32'h0241);
    wb(1'b0, 4'h4, 32'h0);
    chk(q, 32'h28);
    wb(1'b0, 4'h8, 32'h0);
    chk(q, 32'hfe);
    observe(10'h381);
endtask
// ----------------------------------------
// main sequence
// ----------------------------------------
initial
begin
    rows[0] = '{16'h0241, 8'h00, 8'h00, 16'h0241, 8'h20, 8'h18, 10'h3ff};
    rows[1] = '{16'h0000, 8'hff, 8'hff, 16'h0000, 8'hf8, 8'hff, 10'h000};
    rows[2] = '{16'h0249, 8'h80, 8'h41, 16'h0249, 8'ha0, 8'h59, 10'h1ee};
    rows[3] = '{16'ha69f, 8'h48, 8'ha4, 16'h269f, 8'h68, 8'hbc, 10'h293};
    reset_dut(10);
    $display("reset test done");
    for (k = 0; k < 4; k++)
    begin
        wb(1'b1, 4'h0, {16'h0, rows[k].rw});
        wb(1'b1, 4'h4, {24'h0, rows[k].aw});
        wb(1'b1, 4'h8, {24'h0, rows[k].bw});
        wb(1'b0, 4'h0, 32'h0);
        chk(q, {16'h0, rows[k].rr});
        wb(1'b0, 4'h4, 32'h0);
        chk(q, {24'h0, rows[k].ar});
        wb(1'b0, 4'h8, 32'h0);
        chk(q, {24'h0, rows[k].br});
        observe(rows[k].sn);
        $display("row test %0d done", k);
    end
    // unmapped slot reads zero
    wb(1'b0, 4'h2, 32'h0);
    chk(q, 32'h0);
    $display("unmapped test done");
    // status shows each gate running where its stop bit is clear
    wb(1'b0, 4'hc, 32'h0);
    chk(q, 32'h293);
    // a stop write without byte lane 0 is refused
    wb_sel_i <= 4'h0;
    wb(1'b1, 4'h4, 32'h0);
    wb_sel_i <= 4'hf;
    wb(1'b0, 4'h4, 32'h0);
    chk(q, 32'h68);
    $display("status and lane test done");
    reset_dut(3);
    $display("mid-run reset test done");
    print_verdict();
end
endmodule
bind cdg_clock_ctrl cdg_clock_ctrl_chk chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .core_clk_en_o, .bus_clk_en_o,
    .peripheral_clk_en_o, .secondary_timer_clock_en_o, .primary_timer_clock_en_o,
    .ram_clk_en_o, .rom_clk_en_o, .data_transfer_controller_clk_en_o,
    .dma_controller_clk_en_o, .secondary_multifunction_timer_clk_en_o,
    .primary_multifunction_timer_clk_en_o, .compare_match_timer_clk_en_o,
    .converter2_clk_en_o, .converter1_clk_en_o, .converter0_clk_en_o);
